/* design/synth_ctrl.v */
// Register-level control of a phase-locked clock synthesizer with an APB slave.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "synth_ctrl_map.vh"

module synth_ctrl #(
  parameter LOCK_CYCLES = `LOCK_CYCLES
) (
  // Clock and reset
  input wire MCLK_I,
  input wire RESETN_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire PREADY_O,
  output reg [31:0] PRDATA_O,
  output wire PSLVERR_O,
  // System state
  input wire WAIT_I,
  input wire STOP_I,
  input wire BREAK_I,
  // Analog loop status and clock inputs
  input wire VCO_LOCKED_I,
  input wire XTAL_CLK_I,
  input wire VCO_CLK_I,
  // Clock unit outputs
  output reg SYNTH_ENABLE_O,
  output reg OSC_ENABLE_O,
  output reg LOOP_TRACK_O,
  output reg [11:0] FEEDBACK_DIV_O,
  output reg [7:0] VCO_CENTRE_O,
  output reg CRYSTAL_CLOCK_OUT_O,
  output reg BASE_CLOCK_OUT_O,
  output reg VCO_CLOCK_OUT_O,
  output reg CLOCK_UNIT_IRQ_O
);

  // ==========================================================================
  // Reset synchroniser
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n = rst_sync_reg;

  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Registers
  reg synth_irq_enable_reg;
  reg synth_irq_flag_reg;
  reg synth_power_on_reg;
  reg base_source_select_reg;
  reg auto_mode_reg;
  reg lock_reg;
  reg track_manual_reg;
  reg track_auto_reg;
  reg [3:0] feedback_divider_high_reg;
  reg [7:0] feedback_divider_low_reg;
  reg [7:0] vco_centre_multiplier_reg;
  reg osc_keep_in_stop_reg;
  reg break_clear_permit_reg;
  reg [15:0] lock_count_reg;

  wire access = PSEL_I & PENABLE_I;
  wire wr = access & PWRITE_I;
  wire rd = access & ~PWRITE_I;
  wire stopped = STOP_I;
  // A zero range setting powers the loop down regardless of the on bit.
  wire synth_active = synth_power_on_reg & range_live(vco_centre_multiplier_reg) & ~stopped;

  // One-cycle APB answer: every access completes in its first access cycle.
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~addr_known(PADDR_I);

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `CTRL_ADDR) || (a == `BW_ADDR) || (a == `MULH_ADDR) ||
                   (a == `MULL_ADDR) || (a == `VRS_ADDR) || (a == `MODE_ADDR);
    end
  endfunction

  // ==========================================================================
  // Lock detector: the analog indication must hold for the settle time.
  // A short analog glitch restarts the count, so lock is never reported early.
  localparam [15:0] LOCK_LIMIT = LOCK_CYCLES[15:0];
  reg [15:0] lock_count_next;
  reg lock_next;
  wire lock_now = auto_mode_reg & synth_active & (lock_count_reg >= LOCK_LIMIT);

  always @* begin
    lock_count_next = lock_count_reg;
    if (!(synth_active && VCO_LOCKED_I)) begin
      lock_count_next = 16'h0000;
    end else if (lock_count_reg < LOCK_LIMIT) begin
      lock_count_next = lock_count_reg + 16'h0001;
    end
    lock_next = lock_now;
  end

  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lock_count_reg <= 16'h0000;
      lock_reg <= 1'b0;
    end else begin
      lock_count_reg <= lock_count_next;
      lock_reg <= lock_next;
    end
  end

  wire lock_change = auto_mode_reg & (lock_now != lock_reg);
  // Reads in break clear the flag only when the break permit allows it.
  wire flag_read_clear = rd & (PADDR_I == `CTRL_ADDR) & (~BREAK_I | break_clear_permit_reg);

  // ==========================================================================
  // Address decode of the bus request
  wire hit_ctrl = (PADDR_I == `CTRL_ADDR);
  wire hit_bw = (PADDR_I == `BW_ADDR);
  wire hit_mulh = (PADDR_I == `MULH_ADDR);
  wire hit_mull = (PADDR_I == `MULL_ADDR);
  wire hit_vrs = (PADDR_I == `VRS_ADDR);
  wire hit_mode = (PADDR_I == `MODE_ADDR);

  reg synth_irq_enable_next;
  reg synth_irq_flag_next;
  reg synth_power_on_next;
  reg base_source_select_next;
  reg auto_mode_next;
  reg track_manual_next;
  reg track_auto_next;
  reg [3:0] feedback_divider_high_next;
  reg [7:0] feedback_divider_low_next;
  reg [7:0] vco_centre_multiplier_next;
  reg osc_keep_in_stop_next;
  reg break_clear_permit_next;

  // A range of zero parks the loop; used by power gating and base selection alike.
  function range_live;
    input [7:0] r;
    begin
      range_live = (r != 8'h00);
    end
  endfunction

  // ==========================================================================
  // Register next values
  always @* begin
    // Every next value but track_auto_next defaults to the held one, so no path infers a latch.
    synth_irq_enable_next = synth_irq_enable_reg;
    synth_irq_flag_next = synth_irq_flag_reg;
    synth_power_on_next = synth_power_on_reg;
    base_source_select_next = base_source_select_reg;
    auto_mode_next = auto_mode_reg;
    track_manual_next = track_manual_reg;
    track_auto_next = lock_now;
    feedback_divider_high_next = feedback_divider_high_reg;
    feedback_divider_low_next = feedback_divider_low_reg;
    vco_centre_multiplier_next = vco_centre_multiplier_reg;
    osc_keep_in_stop_next = osc_keep_in_stop_reg;
    break_clear_permit_next = break_clear_permit_reg;
    // Set wins over the read clear so no lock change is lost.
    if (lock_change) begin
      synth_irq_flag_next = 1'b1;
    end else if (flag_read_clear || !auto_mode_reg) begin
      synth_irq_flag_next = 1'b0;
    end
    if (wr && hit_ctrl) begin
      if (auto_mode_reg) begin
        synth_irq_enable_next = PWDATA_I[`CTRL_IE_BIT];
      end
      // The on bit cannot drop while the VCO drives the base clock.
      synth_power_on_next = PWDATA_I[`CTRL_PON_BIT] | base_source_select_reg;
      // Selection is allowed while unlocked; only power and range gate it.
      base_source_select_next = PWDATA_I[`CTRL_BCS_BIT] & synth_power_on_reg &
                                range_live(vco_centre_multiplier_reg);
    end else if (!range_live(vco_centre_multiplier_reg)) begin
      base_source_select_next = 1'b0;
    end
    // Manual mode holds the enable clear, so a stale enable never fires later.
    if (!auto_mode_reg) begin
      synth_irq_enable_next = 1'b0;
    end
    if (wr && hit_bw) begin
      // The lock bit position is a test hook; the written value is discarded.
      auto_mode_next = PWDATA_I[`BW_AUTO_BIT];
      if (!auto_mode_reg) begin
        track_manual_next = PWDATA_I[`BW_TRACK_BIT];
      end
    end
    // Power on freezes divider and range, so the loop never sees a half-written setting.
    if (wr && !synth_power_on_reg) begin
      if (hit_mulh) begin
        feedback_divider_high_next = PWDATA_I[3:0];
      end else if (hit_mull) begin
        feedback_divider_low_next = PWDATA_I[7:0];
      end else if (hit_vrs) begin
        vco_centre_multiplier_next = PWDATA_I[7:0];
      end
    end
    // Keep-oscillator and break permit stand in for the system option registers.
    if (wr && hit_mode) begin
      osc_keep_in_stop_next = PWDATA_I[`MODE_OSC_KEEP_BIT];
      break_clear_permit_next = PWDATA_I[`MODE_BCFP_BIT];
    end
  end

  // ==========================================================================
  // Register update
  // Only constants load on reset; every decision is made in the next-value logic.
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      synth_irq_enable_reg <= 1'b0;
      synth_irq_flag_reg <= 1'b0;
      synth_power_on_reg <= 1'b1;
      base_source_select_reg <= 1'b0;
      auto_mode_reg <= 1'b0;
      track_manual_reg <= 1'b0;
      track_auto_reg <= 1'b0;
      feedback_divider_high_reg <= `MULH_RESET;
      feedback_divider_low_reg <= `MULL_RESET;
      vco_centre_multiplier_reg <= `VRS_RESET;
      osc_keep_in_stop_reg <= 1'b0;
      break_clear_permit_reg <= 1'b0;
    end else begin
      synth_irq_enable_reg <= synth_irq_enable_next;
      synth_irq_flag_reg <= synth_irq_flag_next;
      synth_power_on_reg <= synth_power_on_next;
      base_source_select_reg <= base_source_select_next;
      auto_mode_reg <= auto_mode_next;
      track_manual_reg <= track_manual_next;
      track_auto_reg <= track_auto_next;
      feedback_divider_high_reg <= feedback_divider_high_next;
      feedback_divider_low_reg <= feedback_divider_low_next;
      vco_centre_multiplier_reg <= vco_centre_multiplier_next;
      osc_keep_in_stop_reg <= osc_keep_in_stop_next;
      break_clear_permit_reg <= break_clear_permit_next;
    end
  end

  // ==========================================================================
  // Read data
  wire track_now = auto_mode_reg ? track_auto_reg : track_manual_reg;
  reg [31:0] read_next;

  // Read data is taken in the setup cycle so it stands through the whole access phase.
  always @* begin
    read_next = 32'h00000000;
    if (hit_ctrl) begin
      read_next = {24'h000000, synth_irq_enable_reg, synth_irq_flag_reg & auto_mode_reg,
                   synth_power_on_reg, base_source_select_reg, 4'h0};
    end else if (hit_bw) begin
      read_next = {24'h000000, auto_mode_reg, lock_reg & auto_mode_reg, track_now,
                   5'h00};
    end else if (hit_mulh) begin
      read_next = {28'h0000000, feedback_divider_high_reg};
    end else if (hit_mull) begin
      read_next = {24'h000000, feedback_divider_low_reg};
    end else if (hit_vrs) begin
      read_next = {24'h000000, vco_centre_multiplier_reg};
    end else if (hit_mode) begin
      read_next = {30'h00000000, break_clear_permit_reg, osc_keep_in_stop_reg};
    end
  end

  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= read_next;
    end
  end

  // ==========================================================================
  // Clock unit outputs. Wait is deliberately not looked at.
  wire [11:0] mul_raw = {feedback_divider_high_reg, feedback_divider_low_reg};
  reg xtal_div_reg;
  reg vco_div_reg;
  reg xtal_div_next;
  reg vco_div_next;
  reg synth_enable_next;
  reg osc_enable_next;
  reg loop_track_next;
  reg [11:0] feedback_div_next;
  reg [7:0] vco_centre_next;
  reg crystal_clock_next;
  reg base_clock_next;
  reg vco_clock_next;
  reg irq_next;
  wire osc_on = ~stopped | osc_keep_in_stop_reg;

  // Registered outputs keep decode glitches off the clock and interrupt lines.
  always @* begin
    synth_enable_next = synth_active;
    osc_enable_next = osc_on;
    loop_track_next = track_now;
    feedback_div_next = (mul_raw == `MUL_ZERO) ? `MUL_ONE : mul_raw;
    vco_centre_next = vco_centre_multiplier_reg;
    xtal_div_next = osc_on ? ~xtal_div_reg : 1'b0;
    vco_div_next = synth_active ? ~vco_div_reg : 1'b0;
    crystal_clock_next = osc_on & XTAL_CLK_I;
    vco_clock_next = synth_active & VCO_CLK_I;
    // Stop holds the base clock low whichever source is selected.
    base_clock_next = stopped ? 1'b0 :
                      (base_source_select_reg ? vco_div_reg : xtal_div_reg);
    // The interrupt is a level; it falls once software reads the flag clear.
    irq_next = ~stopped & auto_mode_reg & synth_irq_enable_reg &
               synth_irq_flag_reg;
  end

  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SYNTH_ENABLE_O <= 1'b0;
      OSC_ENABLE_O <= 1'b0;
      LOOP_TRACK_O <= 1'b0;
      FEEDBACK_DIV_O <= `MUL_ONE;
      VCO_CENTRE_O <= 8'h00;
      CRYSTAL_CLOCK_OUT_O <= 1'b0;
      BASE_CLOCK_OUT_O <= 1'b0;
      VCO_CLOCK_OUT_O <= 1'b0;
      CLOCK_UNIT_IRQ_O <= 1'b0;
      xtal_div_reg <= 1'b0;
      vco_div_reg <= 1'b0;
    end else begin
      SYNTH_ENABLE_O <= synth_enable_next;
      OSC_ENABLE_O <= osc_enable_next;
      LOOP_TRACK_O <= loop_track_next;
      FEEDBACK_DIV_O <= feedback_div_next;
      VCO_CENTRE_O <= vco_centre_next;
      xtal_div_reg <= xtal_div_next;
      vco_div_reg <= vco_div_next;
      CRYSTAL_CLOCK_OUT_O <= crystal_clock_next;
      VCO_CLOCK_OUT_O <= vco_clock_next;
      BASE_CLOCK_OUT_O <= base_clock_next;
      CLOCK_UNIT_IRQ_O <= irq_next;
    end
  end

  wire unused_ok = WAIT_I;

endmodule // synth_ctrl
`default_nettype wire

/* design/synth_ctrl_map.vh */
// Register offsets, field positions, reset values and timing counts of the synthesizer control.
`ifndef SYNTH_CTRL_MAP_VH
`define SYNTH_CTRL_MAP_VH
// ==========================================================================
// Register byte addresses
`define CTRL_ADDR 12'h000
`define BW_ADDR 12'h004
`define MULH_ADDR 12'h008
`define MULL_ADDR 12'h00C
`define VRS_ADDR 12'h010
`define MODE_ADDR 12'h014
// ==========================================================================
// Control register fields
`define CTRL_IE_BIT 7
`define CTRL_FLAG_BIT 6
`define CTRL_PON_BIT 5
`define CTRL_BCS_BIT 4
// Bandwidth register fields
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_TRACK_BIT 5
// Mode register fields
`define MODE_OSC_KEEP_BIT 0
`define MODE_BCFP_BIT 1
// ==========================================================================
// Reset values
`define MULL_RESET 8'h40
`define MULH_RESET 4'h0
`define VRS_RESET 8'h40
`define MUL_ZERO 12'h000
`define MUL_ONE 12'h001
// ==========================================================================
// Lock detector timing
`define LOCK_TIME_NS 1000
`define CLK_PERIOD_NS 40
`define LOCK_CYCLES ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* verification/synth_ctrl_properties.sv */
// Concurrent checks on the synthesizer control ports.
`timescale 1ns/1ps
`default_nettype none
`include "synth_ctrl_map.vh"
module synth_ctrl_checker #(
  parameter LOCK_CYCLES = 25
) (
  // Clock, reset and bus
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  // State and outputs
  input wire logic STOP_I,
  input wire logic SYNTH_ENABLE_O,
  input wire logic OSC_ENABLE_O,
  input wire logic [11:0] FEEDBACK_DIV_O,
  input wire logic [7:0] VCO_CENTRE_O,
  input wire logic CRYSTAL_CLOCK_OUT_O,
  input wire logic BASE_CLOCK_OUT_O,
  input wire logic CLOCK_UNIT_IRQ_O
);
  // ==========================================================================
  // Helpers
  // The settle count keeps the load of reset values from looking like a write.
  logic [2:0] up_cnt;
  wire logic acc_rd = PSEL_I & PENABLE_I & !PWRITE_I;
  wire logic acc_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire logic mul_wr = acc_wr & (PADDR_I == `MULH_ADDR || PADDR_I == `MULL_ADDR);
  wire logic vrs_wr = acc_wr & (PADDR_I == `VRS_ADDR);
  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // ==========================================================================
  // Properties
  a_stop_outputs_low: assert property (STOP_I [*3] |-> !BASE_CLOCK_OUT_O &&
    !CLOCK_UNIT_IRQ_O && (OSC_ENABLE_O || !CRYSTAL_CLOCK_OUT_O)) else $error("stop outputs");
  a_stop_synth_off: assert property (STOP_I [*3] |-> !SYNTH_ENABLE_O) else $error("synth on");
  a_div_not_zero: assert property (FEEDBACK_DIV_O != 12'h000) else $error("divider zero");
  a_mulh_upper_zero: assert property (acc_rd && PADDR_I == `MULH_ADDR |->
    PRDATA_O[7:4] == 4'h0) else $error("high nibble set");
  a_lock_manual_zero: assert property (acc_rd && PADDR_I == `BW_ADDR && !PRDATA_O[7]
    |-> !PRDATA_O[6]) else $error("lock seen in manual");
  a_div_by_write: assert property (up_cnt == 3'h7 && $changed(FEEDBACK_DIV_O) |->
    $past(mul_wr) || $past(mul_wr, 2) || $past(mul_wr, 3)) else $error("divider moved");
  a_range_by_write: assert property (up_cnt == 3'h7 && $changed(VCO_CENTRE_O) |->
    $past(vrs_wr) || $past(vrs_wr, 2) || $past(vrs_wr, 3)) else $error("range moved");
  a_synth_needs_range: assert property (SYNTH_ENABLE_O |-> VCO_CENTRE_O != 8'h00)
    else $error("synth on with range zero");
endmodule // synth_ctrl_checker
bind synth_ctrl synth_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.MCLK_I(MCLK_I),
  .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .STOP_I(STOP_I), .SYNTH_ENABLE_O(SYNTH_ENABLE_O),
  .OSC_ENABLE_O(OSC_ENABLE_O), .FEEDBACK_DIV_O(FEEDBACK_DIV_O), .VCO_CENTRE_O(VCO_CENTRE_O),
  .CRYSTAL_CLOCK_OUT_O(CRYSTAL_CLOCK_OUT_O), .BASE_CLOCK_OUT_O(BASE_CLOCK_OUT_O),
  .CLOCK_UNIT_IRQ_O(CLOCK_UNIT_IRQ_O));
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the synthesizer control.
`timescale 1ns/1ps
`default_nettype none
`include "synth_ctrl_map.vh"
module tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic wt = 1'b0, stp = 1'b0, brk = 1'b0, lck = 1'b0, xtal = 1'b0, vco = 1'b0, serr;
  wire logic pready, pslverr, syn_en, osc_en, track, xo, bo, vo, irq;
  wire logic [31:0] prdata;
  wire logic [11:0] div;
  wire logic [7:0] centre;
  int n_fail = 0;
  int n_tests = 0;
  synth_ctrl #(.LOCK_CYCLES(2)) dut (.MCLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .WAIT_I(wt), .STOP_I(stp),
    .BREAK_I(brk), .VCO_LOCKED_I(lck), .XTAL_CLK_I(xtal), .VCO_CLK_I(vco),
    .SYNTH_ENABLE_O(syn_en), .OSC_ENABLE_O(osc_en), .LOOP_TRACK_O(track),
    .FEEDBACK_DIV_O(div), .VCO_CENTRE_O(centre), .CRYSTAL_CLOCK_OUT_O(xo),
    .BASE_CLOCK_OUT_O(bo), .VCO_CLOCK_OUT_O(vo), .CLOCK_UNIT_IRQ_O(irq));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    xtal <= ~xtal;
    vco <= ~vco;
  end
  // ==========================================================================
  // Bus and compare tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdata & {24'h0, m}, {24'h0, e});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // Scenarios
  task s_reset;
    rd(`CTRL_ADDR, 8'hFF, 8'h20);
    rd(`BW_ADDR, 8'hFF, 8'h00);
    rd(`MULH_ADDR, 8'hFF, 8'h00);
    rd(`MULL_ADDR, 8'hFF, 8'h40);
    rd(`VRS_ADDR, 8'hFF, 8'h40);
    chk({20'h0, div}, 32'h040);
    chk({24'h0, centre}, 32'h40);
    xfer(1'b0, 12'h018, 8'h00);
    chk({31'h0, serr}, 32'h1);
  endtask
  task s_protect;
    wr(`MULL_ADDR, 8'h55);
    wr(`VRS_ADDR, 8'h11);
    rd(`MULL_ADDR, 8'hFF, 8'h40);
    rd(`VRS_ADDR, 8'hFF, 8'h40);
    wr(`CTRL_ADDR, 8'h00);
    wr(`MULH_ADDR, 8'hFF);
    rd(`MULH_ADDR, 8'hFF, 8'h0F);
    wr(`MULH_ADDR, 8'h00);
    wr(`MULL_ADDR, 8'h00);
    cyc(3);
    chk({20'h0, div}, 32'h001);
    wr(`MULH_ADDR, 8'h01);
    wr(`MULL_ADDR, 8'h23);
    cyc(3);
    chk({20'h0, div}, 32'h123);
    wr(`VRS_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h20);
    wr(`CTRL_ADDR, 8'h30);
    rd(`CTRL_ADDR, 8'h30, 8'h20);
    chk({31'h0, syn_en}, 32'h0);
    chk({31'h0, vo}, 32'h0);
    wr(`CTRL_ADDR, 8'h00);
    wr(`VRS_ADDR, 8'h40);
    wr(`CTRL_ADDR, 8'h20);
    wr(`CTRL_ADDR, 8'h30);
    rd(`CTRL_ADDR, 8'h30, 8'h30);
    wr(`CTRL_ADDR, 8'h00);
    rd(`CTRL_ADDR, 8'h30, 8'h20);
  endtask
  task s_lock;
    wr(`BW_ADDR, 8'h20);
    rd(`BW_ADDR, 8'hFF, 8'h20);
    chk({31'h0, track}, 32'h1);
    wr(`BW_ADDR, 8'hA0);
    wr(`CTRL_ADDR, 8'hA0);
    lck <= 1'b1;
    cyc(10);
    rd(`BW_ADDR, 8'hC0, 8'hC0);
    chk({31'h0, irq}, 32'h1);
    rd(`CTRL_ADDR, 8'hC0, 8'hC0);
    rd(`CTRL_ADDR, 8'hC0, 8'h80);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
  endtask
  task s_break;
    lck <= 1'b0;
    cyc(6);
    brk <= 1'b1;
    rd(`CTRL_ADDR, 8'h40, 8'h40);
    rd(`CTRL_ADDR, 8'h40, 8'h40);
    wr(`MODE_ADDR, 8'h02);
    rd(`CTRL_ADDR, 8'h40, 8'h40);
    brk <= 1'b0;
    rd(`CTRL_ADDR, 8'h40, 8'h00);
    lck <= 1'b1;
    wr(`BW_ADDR, 8'h00);
    cyc(8);
    rd(`BW_ADDR, 8'hFF, 8'h20);
    rd(`CTRL_ADDR, 8'hC0, 8'h00);
  endtask
  task s_stop;
    wt <= 1'b1;
    cyc(4);
    chk({19'h0, syn_en, div}, 32'h1123);
    wt <= 1'b0;
    wr(`MODE_ADDR, 8'h00);
    stp <= 1'b1;
    cyc(4);
    repeat (4) begin
      @(negedge clk);
      chk({28'h0, osc_en, xo, bo, irq}, 32'h0);
    end
    @(posedge clk);
    stp <= 1'b0;
    wr(`MODE_ADDR, 8'h01);
    stp <= 1'b1;
    cyc(4);
    chk({30'h0, osc_en, syn_en}, 32'h2);
    stp <= 1'b0;
  endtask
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    #400000;
    n_fail++;
    give_verdict;
  end
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(4);
    s_reset;
    s_protect;
    s_lock;
    s_break;
    s_stop;
    cyc(2);
    give_verdict;
  end
endmodule // tb
`default_nettype wire
